// >>> design/smb_defines.svh
// constants for the serial management slave and its bus master
`ifndef SMB_DEFINES_SVH
`define SMB_DEFINES_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SMB_CLK_MHZ 200
`define SMB_MEAS_TIME_US 9600
`define SMB_MEAS_CYCLES (`SMB_MEAS_TIME_US * `SMB_CLK_MHZ)
`define SMB_RRST_TIME_NS 1000
`define SMB_RRST_CYCLES (`SMB_RRST_TIME_NS * `SMB_CLK_MHZ / 1000)
`define SMB_SCL_QUARTER 12
// ----------------------------------------
// addressing and framing
// ----------------------------------------
`define SMB_DEV_ADDR 7'h2E
`define SMB_DIR_WRITE 1'b0
`define SMB_DIR_READ 1'b1
`define SMB_BITS_PER_BYTE 4'h8
`define SMB_AVG_SAMPLES 5'h10
// ----------------------------------------
// register pointer values
// ----------------------------------------
`define SMB_REG_CFG 8'h00
`define SMB_REG_INT_STAT 8'h01
`define SMB_REG_INT_MASK 8'h02
`define SMB_REG_INT_TEMP 8'h03
`define SMB_REG_EXT_TEMP 8'h04
`define SMB_REG_EXT_HI 8'h05
`define SMB_REG_EXT_LO 8'h06
`define SMB_REG_AOUT 8'h07
`define SMB_REG_ALERT 8'h08
`define SMB_REG_RFUNC 8'h09
`define SMB_REG_RAMP 8'h0A
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SMB_CFG_ALARM_EN 1
`define SMB_INT_EXT_HI 0
`define SMB_INT_EXT_LO 1
`define SMB_INT_GPI 4
`define SMB_RFUNC_RST 0
`define SMB_RFUNC_OFF 1
`define SMB_RAMP_EN 0
`define SMB_CFG_RESET 8'h00
`define SMB_MASK_RESET 8'h00
`define SMB_EXT_HI_RESET 8'h7F
`define SMB_EXT_LO_RESET 8'h80
`define SMB_AOUT_RESET 8'h00
`define SMB_RAMP_RESET 8'h00
`endif

// >>> design/smb_dev.sv
// slave end: byte protocol, register pointer, registers, averaging and outputs
`timescale 1ns/1ps
`include "smb_defines.svh"
// Functional notes
// - answer only own seven-bit address 0101110
// - detect start: data falls, clock high
// - shift address msb first, then direction
// - acknowledge own address before ninth pulse
// - direction 0 writes, 1 reads
// - nine pulses per byte, last acknowledges
// - data rising while clock high is stop
// - master ends write with stop
// - master ends read with nack, stop
// - direction change needs new start, address
// - writes of one or two bytes, one-byte reads
// - first written byte loads register pointer
// - second written byte goes to pointed register
// - read: pointer write, repeated start, read
// - temperatures are signed two's complement degrees
// - external result averages sixteen measurements
// - new external result every 9.6 ms
// - mask register masks each interrupt source
// - remote function register drives reset, power-off
// - ramp register enables ramp, sets rate
// - alarm output only when config bit 1
module smb_dev
  import smb_pkg::*;
#(
  parameter int MEAS_CYCLES = `SMB_MEAS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  smb_if.dev bus,
  input wire logic [7:0] int_temp,
  input wire logic [7:0] ext_sample,
  input wire logic ext_sample_valid,
  input wire logic general_purpose_input,
  input wire logic sys_power_n,
  output logic alarm_req_n,
  output logic remote_rst_n,
  output logic remote_off,
  output logic [7:0] dac_code
);
  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic [3:0] s1_reg, s2_reg;
  logic [1:0] s3_reg;
  logic scl_rise, scl_fall, start_det, stop_det, sda_s, gpi_s, pwr_s;
  // order: sys_power_n, general_purpose_input, scl, sda
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: power high, input low, clock and data high; no false status after reset
      s1_reg <= 4'hB;
      s2_reg <= 4'hB;
      s3_reg <= 2'h3;
    end else begin
      s1_reg <= {sys_power_n, general_purpose_input, bus.scl, bus.sda};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[1:0];
    end
  end
  assign sda_s = s2_reg[0];
  assign gpi_s = s2_reg[2];
  assign pwr_s = s2_reg[3];
  assign scl_rise = s2_reg[1] && !s3_reg[1];
  assign scl_fall = !s2_reg[1] && s3_reg[1];
  assign start_det = s2_reg[1] && s3_reg[1] && !sda_s && s3_reg[0];
  assign stop_det = s2_reg[1] && s3_reg[1] && sda_s && !s3_reg[0];
  // ----------------------------------------
  // register file and read decode
  // ----------------------------------------
  logic [7:0] cfg_reg, cfg_next, stat_reg, stat_next, mask_reg, mask_next;
  logic [7:0] hi_reg, hi_next, lo_reg, lo_next, aout_reg, aout_next, ramp_reg, ramp_next;
  logic [7:0] ext_reg, ext_next, dac_reg, dac_next, rrst_cnt_reg, rrst_cnt_next;
  logic off_reg, off_next, alarm_n_reg, alarm_n_next;
  logic [23:0] tmr_reg, tmr_next;
  logic [11:0] acc_reg, acc_next;
  logic [4:0] scnt_reg, scnt_next;
  logic [7:0] ptr_reg, ptr_next, sh_reg, sh_next, rd_byte;
  logic wr_stb, rd_stb;

  // read value of the register the pointer selects, unmapped read as zero
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    case (p)
      `SMB_REG_CFG: rd_mux = cfg_reg;
      `SMB_REG_INT_STAT: rd_mux = stat_reg;
      `SMB_REG_INT_MASK: rd_mux = mask_reg;
      `SMB_REG_INT_TEMP: rd_mux = int_temp;
      `SMB_REG_EXT_TEMP: rd_mux = ext_reg;
      `SMB_REG_EXT_HI: rd_mux = hi_reg;
      `SMB_REG_EXT_LO: rd_mux = lo_reg;
      `SMB_REG_AOUT: rd_mux = aout_reg;
      `SMB_REG_ALERT: rd_mux = {6'h00, gpi_s, ($signed(ext_reg) > $signed(hi_reg))};
      `SMB_REG_RFUNC: rd_mux = {6'h00, off_reg, (rrst_cnt_reg != 8'h00)};
      `SMB_REG_RAMP: rd_mux = ramp_reg;
      default: rd_mux = 8'h00;
    endcase
  endfunction
  assign rd_byte = rd_mux(ptr_reg);
  // ----------------------------------------
  // byte protocol engine
  // ----------------------------------------
  smb_dev_state_type st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] nbyte_reg, nbyte_next;
  logic dir_reg, dir_next, oe_n_reg, oe_n_next;

  // bits are taken on clock rise, the data line changes on clock fall
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    dir_next = dir_reg;
    nbyte_next = nbyte_reg;
    oe_n_next = oe_n_reg;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (start_det) begin
      st_next = DS_ADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (stop_det) begin
      st_next = DS_IDLE;
      oe_n_next = 1'b1;
    end else if (scl_rise) begin
      case (st_reg)
        DS_ADDR, DS_WR: begin
          sh_next = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end
        DS_RD: begin
          sh_next = {sh_reg[6:0], 1'b1};
          cnt_next = cnt_reg + 4'h1;
        end
        DS_RD_ACK: begin
          if (sda_s) begin
            st_next = DS_IGNORE;
          end else begin
            st_next = DS_RD;
            cnt_next = 4'h0;
            sh_next = rd_byte;
            rd_stb = 1'b1;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_reg)
        DS_ADDR: begin
          if (cnt_reg == `SMB_BITS_PER_BYTE) begin
            if (sh_reg[7:1] == `SMB_DEV_ADDR) begin
              st_next = DS_ACK_A;
              oe_n_next = 1'b0;
              dir_next = sh_reg[0];
            end else begin
              st_next = DS_IGNORE;
            end
          end
        end
        DS_ACK_A: begin
          cnt_next = 4'h0;
          nbyte_next = 2'h0;
          if (dir_reg == `SMB_DIR_READ) begin
            st_next = DS_RD;
            sh_next = rd_byte;
            oe_n_next = rd_byte[7];
            rd_stb = 1'b1;
          end else begin
            st_next = DS_WR;
            oe_n_next = 1'b1;
          end
        end
        DS_WR: begin
          if (cnt_reg == `SMB_BITS_PER_BYTE) begin
            if (nbyte_reg == 2'h0) begin
              ptr_next = sh_reg;
              st_next = DS_ACK_W;
              oe_n_next = 1'b0;
            end else if (nbyte_reg == 2'h1) begin
              wr_stb = 1'b1;
              st_next = DS_ACK_W;
              oe_n_next = 1'b0;
            end else begin
              st_next = DS_IGNORE;
            end
            nbyte_next = nbyte_reg + 2'h1;
          end
        end
        DS_ACK_W: begin
          st_next = DS_WR;
          cnt_next = 4'h0;
          oe_n_next = 1'b1;
        end
        DS_RD: begin
          if (cnt_reg == `SMB_BITS_PER_BYTE) begin
            st_next = DS_RD_ACK;
            oe_n_next = 1'b1;
          end else begin
            oe_n_next = sh_reg[7];
          end
        end
        default: oe_n_next = 1'b1;
      endcase
    end
  end

  // protocol state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= DS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      dir_reg <= `SMB_DIR_WRITE;
      nbyte_reg <= 2'h0;
      oe_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      dir_reg <= dir_next;
      nbyte_reg <= nbyte_next;
      oe_n_reg <= oe_n_next;
    end
  end
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = oe_n_reg;
  // ----------------------------------------
  // registers, measurement, ramp and outputs
  // ----------------------------------------
  logic meas_tick;
  logic [7:0] avg, step;
  logic [8:0] up, dn;
  assign meas_tick = (tmr_reg == 24'(MEAS_CYCLES - 1));
  assign avg = acc_reg[11:4];
  assign step = {5'h00, ramp_reg[3:1]} + 8'h01;
  assign up = {1'b0, dac_reg} + {1'b0, step};
  assign dn = {1'b0, dac_reg} - {1'b0, step};

  // register writes, sticky status with set over clear-on-read, averaging, ramp
  always_comb begin
    cfg_next = cfg_reg;
    mask_next = mask_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    aout_next = aout_reg;
    ramp_next = ramp_reg;
    off_next = off_reg;
    ext_next = ext_reg;
    rrst_cnt_next = (rrst_cnt_reg != 8'h00) ? rrst_cnt_reg - 8'h01 : 8'h00;
    stat_next = (rd_stb && ptr_reg == `SMB_REG_INT_STAT) ? 8'h00 : stat_reg;
    if (wr_stb) begin
      case (ptr_reg)
        `SMB_REG_CFG: cfg_next = sh_reg;
        `SMB_REG_INT_MASK: mask_next = sh_reg;
        `SMB_REG_EXT_HI: hi_next = sh_reg;
        `SMB_REG_EXT_LO: lo_next = sh_reg;
        `SMB_REG_AOUT: aout_next = sh_reg;
        `SMB_REG_RAMP: ramp_next = sh_reg;
        `SMB_REG_RFUNC: begin
          if (sh_reg[`SMB_RFUNC_RST]) rrst_cnt_next = 8'(`SMB_RRST_CYCLES);
          if (sh_reg[`SMB_RFUNC_OFF]) off_next = 1'b1;
        end
        default: ;
      endcase
    end
    if (!pwr_s) off_next = 1'b0;
    tmr_next = meas_tick ? 24'h000000 : tmr_reg + 24'h000001;
    acc_next = acc_reg;
    scnt_next = scnt_reg;
    if (meas_tick) begin
      acc_next = 12'h000;
      scnt_next = 5'h00;
      if (scnt_reg == `SMB_AVG_SAMPLES) begin
        ext_next = avg;
        if ($signed(avg) > $signed(hi_reg)) stat_next[`SMB_INT_EXT_HI] = 1'b1;
        if ($signed(avg) < $signed(lo_reg)) stat_next[`SMB_INT_EXT_LO] = 1'b1;
      end
    end else if (ext_sample_valid && scnt_reg != `SMB_AVG_SAMPLES) begin
      acc_next = acc_reg + {{4{ext_sample[7]}}, ext_sample};
      scnt_next = scnt_reg + 5'h01;
    end
    if (gpi_s) stat_next[`SMB_INT_GPI] = 1'b1;
    dac_next = dac_reg;
    if (!ramp_reg[`SMB_RAMP_EN]) begin
      dac_next = aout_reg;
    end else if (meas_tick && dac_reg < aout_reg) begin
      dac_next = (up[8] || up[7:0] > aout_reg) ? aout_reg : up[7:0];
    end else if (meas_tick && dac_reg > aout_reg) begin
      dac_next = (dn[8] || dn[7:0] < aout_reg) ? aout_reg : dn[7:0];
    end
    alarm_n_next = !(cfg_reg[`SMB_CFG_ALARM_EN] && |(stat_reg & ~mask_reg));
  end

  // register file and measurement state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `SMB_CFG_RESET;
      stat_reg <= 8'h00;
      mask_reg <= `SMB_MASK_RESET;
      hi_reg <= `SMB_EXT_HI_RESET;
      lo_reg <= `SMB_EXT_LO_RESET;
      aout_reg <= `SMB_AOUT_RESET;
      ramp_reg <= `SMB_RAMP_RESET;
      off_reg <= 1'b0;
      ext_reg <= 8'h00;
      rrst_cnt_reg <= 8'h00;
      tmr_reg <= 24'h000000;
      acc_reg <= 12'h000;
      scnt_reg <= 5'h00;
      dac_reg <= `SMB_AOUT_RESET;
      alarm_n_reg <= 1'b1;
    end else begin
      cfg_reg <= cfg_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      aout_reg <= aout_next;
      ramp_reg <= ramp_next;
      off_reg <= off_next;
      ext_reg <= ext_next;
      rrst_cnt_reg <= rrst_cnt_next;
      tmr_reg <= tmr_next;
      acc_reg <= acc_next;
      scnt_reg <= scnt_next;
      dac_reg <= dac_next;
      alarm_n_reg <= alarm_n_next;
    end
  end
  assign alarm_req_n = alarm_n_reg;
  assign remote_rst_n = (rrst_cnt_reg == 8'h00);
  assign remote_off = off_reg;
  assign dac_code = dac_reg;
endmodule // smb_dev

// >>> design/smb_host.sv
// master end: clock divider, start/stop and byte sequencing of register access
`timescale 1ns/1ps
`include "smb_defines.svh"
module smb_host
  import smb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  smb_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire smb_op_type cmd_op,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  // ----------------------------------------
  // data line synchroniser
  // ----------------------------------------
  logic s1_reg, s2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= bus.sda;
      s2_reg <= s1_reg;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  smb_host_state_type st_reg, st_next;
  smb_op_type op_reg, op_next;
  logic [7:0] q_reg, q_next, sh_reg, sh_next, ptr_reg, ptr_next, dat_reg, dat_next;
  logic [7:0] rdat_reg, rdat_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [2:0] idx_reg, idx_next;
  logic scl_reg, scl_next, oe_n_reg, oe_n_next, ack_reg, ack_next;
  logic nack_reg, nack_next, rv_reg, rv_next, tick;

  // byte sent at each position of the sequence
  function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic [7:0] p,
                                         input logic [7:0] d);
    case (i)
      3'h0: tx_byte = {`SMB_DEV_ADDR, `SMB_DIR_WRITE};
      3'h1: tx_byte = p;
      3'h2: tx_byte = d;
      3'h3: tx_byte = {`SMB_DEV_ADDR, `SMB_DIR_READ};
      default: tx_byte = 8'hFF;
    endcase
  endfunction

  assign tick = (q_reg == 8'(`SMB_SCL_QUARTER - 1));

  // each bit is four quarter periods: set data, clock high, sample, clock low
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    ptr_next = ptr_reg;
    dat_next = dat_reg;
    rdat_next = rdat_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    idx_next = idx_reg;
    scl_next = scl_reg;
    oe_n_next = oe_n_reg;
    ack_next = ack_reg;
    nack_next = nack_reg;
    rv_next = 1'b0;
    q_next = tick ? 8'h00 : q_reg + 8'h01;
    ph_next = ph_reg;
    if (st_reg == HS_IDLE) begin
      q_next = 8'h00;
      ph_next = 2'h0;
      if (cmd_valid) begin
        st_next = HS_START;
        op_next = cmd_op;
        ptr_next = cmd_ptr;
        dat_next = cmd_data;
        idx_next = 3'h0;
        nack_next = 1'b0;
      end
    end else if (tick) begin
      ph_next = ph_reg + 2'h1;
      case (st_reg)
        HS_START: begin
          case (ph_reg)
            2'h0: oe_n_next = 1'b1;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b0;
            default: begin
              scl_next = 1'b0;
              sh_next = tx_byte(idx_reg, ptr_reg, dat_reg);
              bit_next = 4'h0;
              st_next = HS_BIT;
            end
          endcase
        end
        HS_BIT: begin
          case (ph_reg)
            2'h0: oe_n_next = (bit_reg == `SMB_BITS_PER_BYTE) || (idx_reg == 3'h4) || sh_reg[7];
            2'h1: scl_next = 1'b1;
            2'h2: begin
              if (bit_reg == `SMB_BITS_PER_BYTE) ack_next = !s2_reg;
              else sh_next = {sh_reg[6:0], s2_reg};
            end
            default: begin
              scl_next = 1'b0;
              bit_next = bit_reg + 4'h1;
              if (bit_reg == `SMB_BITS_PER_BYTE) begin
                bit_next = 4'h0;
                sh_next = tx_byte(idx_reg + 3'h1, ptr_reg, dat_reg);
                idx_next = idx_reg + 3'h1;
                if (idx_reg == 3'h4) begin
                  rdat_next = sh_reg;
                  st_next = HS_STOP;
                end else if (!ack_reg) begin
                  nack_next = 1'b1;
                  st_next = HS_STOP;
                end else if (idx_reg == 3'h1 && op_reg == OP_PTR) begin
                  st_next = HS_STOP;
                end else if (idx_reg == 3'h1 && op_reg == OP_READ) begin
                  st_next = HS_START;
                  idx_next = 3'h3;
                end else if (idx_reg == 3'h2) begin
                  st_next = HS_STOP;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          case (ph_reg)
            2'h0: oe_n_next = 1'b0;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b1;
            default: begin
              st_next = HS_IDLE;
              rv_next = 1'b1;
            end
          endcase
        end
        default: st_next = HS_IDLE;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= HS_IDLE;
      op_reg <= OP_PTR;
      ptr_reg <= 8'h00;
      dat_reg <= 8'h00;
      rdat_reg <= 8'h00;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      idx_reg <= 3'h0;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      ack_reg <= 1'b0;
      nack_reg <= 1'b0;
      rv_reg <= 1'b0;
      q_reg <= 8'h00;
      ph_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      ptr_reg <= ptr_next;
      dat_reg <= dat_next;
      rdat_reg <= rdat_next;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      scl_reg <= scl_next;
      oe_n_reg <= oe_n_next;
      ack_reg <= ack_next;
      nack_reg <= nack_next;
      rv_reg <= rv_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
    end
  end
  assign cmd_ready = (st_reg == HS_IDLE);
  assign bus.scl = scl_reg;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = oe_n_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = rdat_reg;
  assign rsp_nack = nack_reg;
endmodule // smb_host

// >>> design/smb_if.sv
// two-wire link joining the bus master and the slave
`timescale 1ns/1ps
interface smb_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // open-drain wired-and with pull-up
  assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host(output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface

// >>> design/smb_pkg.sv
// types shared by both ends of the serial management link
package smb_pkg;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_ACK_A, DS_WR, DS_ACK_W, DS_RD, DS_RD_ACK, DS_IGNORE
  } smb_dev_state_type;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} smb_host_state_type;
  typedef enum logic [1:0] {OP_PTR, OP_WRITE, OP_READ} smb_op_type;
endpackage

// >>> testbench/smb_link_sva.sv
// protocol checker for the two-wire link between master and slave
`timescale 1ns/1ps
module smb_link_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic pscl_reg, psda_reg, rd_reg, rd_next, rise, start_ev, stop_ev;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next;
  logic [7:0] sh_reg, sh_next;
  // wire events, bit and byte position, shifted bits
  always_comb begin
    rise = scl && !pscl_reg;
    start_ev = scl && pscl_reg && psda_reg && !sda;
    stop_ev = scl && pscl_reg && !psda_reg && sda;
    bit_next = bit_reg;
    byte_next = byte_reg;
    rd_next = rd_reg;
    sh_next = sh_reg;
    if (start_ev || stop_ev) begin
      bit_next = 4'h0;
      byte_next = 2'h0;
      rd_next = 1'b0;
    end else if (rise) begin
      sh_next = {sh_reg[6:0], sda};
      bit_next = (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      if (bit_reg == 4'h8 && byte_reg != 2'h3) byte_next = byte_reg + 2'h1;
      if (bit_reg == 4'h8 && byte_reg == 2'h0) rd_next = sh_reg[0];
    end
  end
  // register the tracking state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pscl_reg, psda_reg, rd_reg} <= 3'h6;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      sh_reg <= 8'h00;
    end else begin
      {pscl_reg, psda_reg, rd_reg} <= {scl, sda, rd_next};
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      sh_reg <= sh_next;
    end
  end
  property p_addr; rise && bit_reg == 4'h7 && byte_reg == 2'h0 |-> sh_reg[6:0] == 7'h2E; endproperty
  a_addr: assert property (p_addr) else $error("address bits wrong");
  property p_ack; rise && bit_reg == 4'h8 && byte_reg == 2'h0 && sh_reg[7:1] == 7'h2E |-> !sda;
  endproperty
  a_ack: assert property (p_ack) else $error("own address not acked");
  property p_wack; rise && bit_reg == 4'h8 && !rd_reg && byte_reg != 2'h0 |-> !sda; endproperty
  a_wack: assert property (p_wack) else $error("written byte not acked");
  property p_slot; rise && !dev_sda_oe_n && !rd_reg |-> bit_reg == 4'h8; endproperty
  a_slot: assert property (p_slot) else $error("slave drives outside ack slot");
  property p_stable; scl && pscl_reg |-> $stable(dev_sda_oe_n); endproperty
  a_stable: assert property (p_stable) else $error("slave data moved in clock high");
  property p_stop; stop_ev |-> bit_reg == 4'h1; endproperty
  a_stop: assert property (p_stop) else $error("stop off byte boundary");
  property p_start; start_ev |-> ##[1:20] !scl; endproperty
  a_start: assert property (p_start) else $error("no clock after start");
  property p_nack; rise && bit_reg == 4'h8 && rd_reg |-> sda; endproperty
  a_nack: assert property (p_nack) else $error("read byte not nacked");
  c_read: cover property (rise && bit_reg == 4'h8 && rd_reg);
  c_restart: cover property (start_ev && bit_reg == 4'h1);
  c_stop: cover property (stop_ev);
endmodule // smb_link_sva

// >>> testbench/smbus_register_access_slave_tb.sv
// self-checking bench joining the bus master and the slave
`timescale 1ns/1ps
module smbus_register_access_slave_tb;
  import smb_pkg::*;
  localparam int MEAS = 2000;
  logic ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, ext_sample_valid = 1'b0;
  logic general_purpose_input = 1'b0, sys_power_n = 1'b1;
  logic cmd_ready, rsp_valid, rsp_nack, alarm_req_n, remote_rst_n, remote_off;
  logic [7:0] cmd_ptr = 8'h00, cmd_data = 8'h00, int_temp = 8'h00, ext_sample = 8'h00;
  logic [7:0] rsp_data, dac_code, v;
  logic [7:0] smp [16];
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] pl [7] = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h3C};
  logic [7:0] tl [4] = '{8'h80, 8'hE7, 8'h19, 8'h7F};
  smb_op_type cmd_op = OP_PTR;
  int errors = 0, cmp_count = 0, sum;
  smb_if bus ();
  always #2.5 ref_clk = ~ref_clk;
  smb_dev #(.MEAS_CYCLES(MEAS)) i_smb_dev (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus.dev),
    .int_temp(int_temp), .ext_sample(ext_sample), .ext_sample_valid(ext_sample_valid),
    .general_purpose_input(general_purpose_input), .sys_power_n(sys_power_n),
    .alarm_req_n(alarm_req_n), .remote_rst_n(remote_rst_n), .remote_off(remote_off),
    .dac_code(dac_code));
  smb_host i_smb_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  smb_link_sva i_smb_link_sva (.ref_clk(ref_clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .host_sda_o(bus.host_sda_o), .host_sda_oe_n(bus.host_sda_oe_n),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n));
  // compare one result byte
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one command to the master, waiting for its response
  task automatic cmd(smb_op_type op, logic [7:0] p, logic [7:0] d);
    int n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_ptr <= p;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("BAD %0t no response", $time);
    end
    chk({7'h00, rsp_nack}, 8'h00);
  endtask
  task automatic rd(logic [7:0] p, logic [7:0] e);
    cmd(OP_READ, p, 8'h00);
    chk(rsp_data, e);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hung link
  initial begin
    #450000;
    errors++;
    $display("BAD %0t watchdog", $time);
    print_verdict();
  end
  // main sequence
  initial begin
    sum = $urandom(87);
    sum = 0;
    mem[5] = 8'h7F;
    mem[6] = 8'h80;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({7'h00, alarm_req_n}, 8'h01);
    foreach (pl[i]) rd(pl[i], mem[pl[i]]);
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      if (pl[i] == 8'h0A) v[0] = 1'b0;
      cmd(OP_WRITE, pl[i], v);
      cmd(OP_PTR, 8'h03, 8'h00);
      rd(pl[i], v);
      mem[pl[i]] = v;
    end
    chk(dac_code, mem[7]);
    $display("test 2 done");
    foreach (tl[i]) begin
      int_temp <= tl[i];
      rd(8'h03, tl[i]);
    end
    $display("test 3 done");
    for (int k = 0; k < 16; k++) begin
      smp[k] = 8'($urandom);
      sum += $signed(smp[k]);
    end
    // a repeating set of 16: any 16 in a row after a tick give the same sum
    ext_sample_valid <= 1'b1;
    for (int k = 0; k < 2 * MEAS + 40; k++) begin
      ext_sample <= smp[k % 16];
      @(posedge ref_clk);
    end
    ext_sample_valid <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd(8'h04, 8'(sum >>> 4));
    $display("test 4 done");
    cmd(OP_WRITE, 8'h09, 8'h02);
    chk({7'h00, remote_off}, 8'h01);
    sys_power_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({7'h00, remote_off}, 8'h00);
    sys_power_n <= 1'b1;
    cmd(OP_WRITE, 8'h09, 8'h01);
    chk({7'h00, remote_rst_n}, 8'h00);
    repeat (250) @(posedge ref_clk);
    chk({7'h00, remote_rst_n}, 8'h01);
    $display("test 5 done");
    cmd(OP_WRITE, 8'h02, 8'hEF);
    cmd(OP_WRITE, 8'h00, 8'h02);
    chk({7'h00, alarm_req_n}, 8'h01);
    general_purpose_input <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({7'h00, alarm_req_n}, 8'h00);
    cmd(OP_WRITE, 8'h02, 8'hFF);
    chk({7'h00, alarm_req_n}, 8'h01);
    $display("test 6 done");
    // ramp on, step of eight per tick, target sixteen away
    cmd(OP_WRITE, 8'h0A, 8'h0F);
    cmd(OP_WRITE, 8'h07, mem[7] ^ 8'h10);
    chk({7'h00, dac_code == (mem[7] ^ 8'h10)}, 8'h00);
    repeat (2 * MEAS + 10) @(posedge ref_clk);
    chk(dac_code, mem[7] ^ 8'h10);
    $display("test 7 done");
    print_verdict();
  end
endmodule // smbus_register_access_slave_tb
